//--- design/dcpwm_top.sv
// Notes on behaviour
// RULE1: two outputs share one period and prescaler; each has its own duty.
// RULE2: setup bits 7..6 pick 5, 6, 7 or 8 bit resolution.
// RULE3: period is (2^res - 1) times (prescale + 1) clock cycles.
// RULE4: setup bits 5..2 divide output frequency by field plus one.
// RULE5: duty is low res bits of duty register over base count.
// RULE6: setup bit 1 enables channel one onto its pin.
// RULE7: setup bit 0 enables channel zero onto its pin.
// RULE8: duty register writes act on the output immediately.
// RULE9: a period hit by a duty change has high time between old and new.
// RULE10: disabled or zero duty gives low; duty equal base gives constant high.
module dcpwm_top #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic pulse_out_zero,
  output logic pulse_out_one
);
  import dcpwm_pkg::*;

  if (DATA_W != 8) begin : width_check_g
    $error("dcpwm_top serves only 8-bit special function registers");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] pulse_setup;
  logic [7:0] duty_channel_zero;
  logic [7:0] duty_channel_one;
  logic [3:0] pre_cnt;
  logic [7:0] step;

  wire wr_setup = ce && sfr_write && (sfr_addr == DCPWM_ADDR_SETUP);
  wire wr_duty0 = ce && sfr_write && (sfr_addr == DCPWM_ADDR_DUTY_ZERO);
  wire wr_duty1 = ce && sfr_write && (sfr_addr == DCPWM_ADDR_DUTY_ONE);

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_setup <= DCPWM_RESET_VALUE;
      duty_channel_zero <= DCPWM_RESET_VALUE;
      duty_channel_one <= DCPWM_RESET_VALUE;
    end else begin
      if (wr_setup) begin
        pulse_setup <= sfr_wdata;
      end
      if (wr_duty0) begin
        duty_channel_zero <= sfr_wdata;
      end
      if (wr_duty1) begin
        duty_channel_one <= sfr_wdata;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] next_rdata =
    (sfr_addr == DCPWM_ADDR_SETUP) ? pulse_setup :
    (sfr_addr == DCPWM_ADDR_DUTY_ZERO) ? duty_channel_zero :
    (sfr_addr == DCPWM_ADDR_DUTY_ONE) ? duty_channel_one : DCPWM_UNMAPPED_READ;

  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= DCPWM_RESET_VALUE;
    end else if (ce && sfr_read) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // shared timebase
  // ----------------------------------------
  wire dcpwm_res_t res_code = dcpwm_res_t'(pulse_setup[DCPWM_RES_HI:DCPWM_RES_LO]);
  wire [3:0] presc = pulse_setup[DCPWM_PRESC_HI:DCPWM_PRESC_LO];
  wire [7:0] base_count =
    (res_code == DCPWM_RES5) ? DCPWM_BASE5 :
    (res_code == DCPWM_RES6) ? DCPWM_BASE6 :
    (res_code == DCPWM_RES7) ? DCPWM_BASE7 : DCPWM_BASE8; // [RULE2]
  wire [7:0] last_step = base_count - DCPWM_STEP_ONE;
  // >= rather than == so a prescale or resolution drop mid-period cannot strand either count
  wire pre_wrap = pre_cnt >= presc; // [RULE4]
  wire step_wrap = step >= last_step; // [RULE3]
  wire [3:0] next_pre = pre_wrap ? DCPWM_PRE_ZERO : pre_cnt + DCPWM_PRESC_ONE;
  wire [7:0] next_step = !pre_wrap ? step :
    (step_wrap ? DCPWM_STEP_ZERO : step + DCPWM_STEP_ONE);

  always_ff @(posedge clk) begin
    if (reset) begin
      pre_cnt <= DCPWM_PRE_ZERO;
      step <= DCPWM_STEP_ZERO;
    end else if (ce) begin
      pre_cnt <= next_pre; // [RULE4]
      step <= next_step; // [RULE3]
    end
  end

  // ----------------------------------------
  // channel compare
  // ----------------------------------------
  // compare reads the duty register live, so a write lands mid-period and
  // the high time of that period falls between old and new duty
  wire [7:0] duty_reg [2];
  wire [7:0] duty_eff [2];
  wire [1:0] en_ch;
  wire [1:0] next_out;
  assign duty_reg[0] = duty_channel_zero;
  assign duty_reg[1] = duty_channel_one;
  assign en_ch[0] = pulse_setup[DCPWM_EN_ZERO]; // [RULE7]
  assign en_ch[1] = pulse_setup[DCPWM_EN_ONE]; // [RULE6]
  // full duty forced high so a resolution drop cannot notch a constant-high channel
  for (genvar ch = 0; ch < 2; ch++) begin : chan_g
    wire full_ch = duty_eff[ch] == base_count; // [RULE10]
    assign duty_eff[ch] = duty_reg[ch] & base_count; // [RULE5]
    assign next_out[ch] = en_ch[ch] && (full_ch || step < duty_eff[ch]); // [RULE1] [RULE8] [RULE9]
  end
  wire [7:0] duty_eff0 = duty_eff[0];
  wire [7:0] duty_eff1 = duty_eff[1];
  wire en0 = en_ch[0];
  wire en1 = en_ch[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_out_zero <= 1'b0;
      pulse_out_one <= 1'b0;
    end else if (ce) begin
      pulse_out_zero <= next_out[0];
      pulse_out_one <= next_out[1];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  zero_disabled_a: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    ce && !en0 |=> !pulse_out_zero)
    else $error("channel zero high while disabled");

  one_disabled_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
    ce && !en1 |=> !pulse_out_one)
    else $error("channel one high while disabled");

  step_bound_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    ce && !wr_setup && step < last_step |=> step < base_count)
    else $error("step left the selected resolution");

  presc_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    ce && !pre_wrap |=> step == $past(step))
    else $error("step moved before prescaler wrapped");

  step_adv_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    ce && pre_wrap && !step_wrap |=> step == $past(step) + DCPWM_STEP_ONE)
    else $error("step did not advance on prescaler wrap");

  full_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    ce && en0 && duty_eff0 == base_count |=> pulse_out_zero)
    else $error("full duty did not give high");

  zero_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    ce && duty_eff1 == 8'h00 |=> !pulse_out_one)
    else $error("zero duty did not give low");

  live_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    ce && en0 && step < base_count |=> pulse_out_zero == ($past(step) <
      ($past(duty_channel_zero) & $past(base_count))))
    else $error("channel zero did not follow live duty");

  shared_period_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    ce && en0 && en1 && duty_channel_zero == duty_channel_one
      |=> pulse_out_zero == pulse_out_one)
    else $error("channels with equal duty differ");

  count_freeze_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    !ce |=> $stable(step) && $stable(pre_cnt))
    else $error("timebase moved with clock enable low");

  out_freeze_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    !ce |=> $stable(pulse_out_zero) && $stable(pulse_out_one))
    else $error("output moved with clock enable low");

  presc_wrap_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    ce && pre_wrap |=> pre_cnt == DCPWM_PRE_ZERO)
    else $error("prescaler did not restart");

  presc_count_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    ce && !pre_wrap |=> pre_cnt == $past(pre_cnt) + DCPWM_PRESC_ONE)
    else $error("prescaler did not count");

  step_wrap_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    ce && pre_wrap && step_wrap |=> step == DCPWM_STEP_ZERO)
    else $error("step did not restart at period end");

  one_live_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    ce && en1 && step < base_count |=> pulse_out_one == ($past(step) <
      ($past(duty_channel_one) & $past(base_count))))
    else $error("channel one did not follow live duty");

  zero_duty_low_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    ce && duty_eff0 == DCPWM_STEP_ZERO |=> !pulse_out_zero)
    else $error("channel zero with zero duty not low");

  one_full_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    ce && en1 && duty_eff1 == base_count |=> pulse_out_one)
    else $error("channel one full duty did not give high");

  read_duty_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    ce && sfr_read && sfr_addr == DCPWM_ADDR_DUTY_ZERO
      |=> sfr_rdata == $past(duty_channel_zero))
    else $error("duty readback differs from register");

  setup_write_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    wr_setup |=> pulse_setup == $past(sfr_wdata))
    else $error("setup write did not land");

  duty_write_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    wr_duty0 |=> duty_channel_zero == $past(sfr_wdata))
    else $error("channel zero duty write did not land");

  duty_one_write_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    wr_duty1 |=> duty_channel_one == $past(sfr_wdata))
    else $error("channel one duty write did not land");
endmodule

//--- design/dcpwm_pkg.sv
package dcpwm_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] DCPWM_ADDR_DUTY_ZERO = 8'ha1;
  localparam logic [7:0] DCPWM_ADDR_DUTY_ONE = 8'ha2;
  localparam logic [7:0] DCPWM_ADDR_SETUP = 8'hb2;
  localparam logic [7:0] DCPWM_RESET_VALUE = 8'h00;
  localparam logic [7:0] DCPWM_UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // pulse_setup fields
  // ----------------------------------------
  localparam int DCPWM_RES_HI = 7;
  localparam int DCPWM_RES_LO = 6;
  localparam int DCPWM_PRESC_HI = 5;
  localparam int DCPWM_PRESC_LO = 2;
  localparam int DCPWM_EN_ONE = 1;
  localparam int DCPWM_EN_ZERO = 0;

  // ----------------------------------------
  // resolution codes and base counts
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCPWM_RES5 = 2'h0,
    DCPWM_RES6 = 2'h1,
    DCPWM_RES7 = 2'h2,
    DCPWM_RES8 = 2'h3
  } dcpwm_res_t;

  localparam logic [7:0] DCPWM_BASE5 = 8'h1f;
  localparam logic [7:0] DCPWM_BASE6 = 8'h3f;
  localparam logic [7:0] DCPWM_BASE7 = 8'h7f;
  localparam logic [7:0] DCPWM_BASE8 = 8'hff;
  localparam logic [7:0] DCPWM_STEP_ONE = 8'h01;
  localparam logic [3:0] DCPWM_PRESC_ONE = 4'h1;
  localparam logic [3:0] DCPWM_PRE_ZERO = 4'h0;
  localparam logic [7:0] DCPWM_STEP_ZERO = 8'h00;
endpackage

//--- tb/dcpwm_load.sv
// ----------------------------------------
// load on one pin: counts high cycles
// ----------------------------------------
module dcpwm_load (
  input wire logic clk,
  input wire logic pin,
  input wire logic clr,
  input wire logic en,
  output logic [15:0] cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // a window of exactly one period hides the phase of the counters
  always_ff @(posedge clk) begin
    if (clr) cnt <= 16'h0000;
    else if (en) cnt <= cnt + {15'h0000, pin};
  end
endmodule

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, ce = 1, wr_s = 0, rd_s = 0, clr = 0, en = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic p0, p1;
  logic [15:0] c0, c1, base, n;
  int bad_count = 0, compares = 0, cycles = 0;
  dcpwm_top dcpwm_top_inst (.clk(clk), .reset(reset), .ce(ce), .sfr_addr(addr),
    .sfr_write(wr_s), .sfr_read(rd_s), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .pulse_out_zero(p0), .pulse_out_one(p1));
  dcpwm_load load_zero_inst (.clk(clk), .pin(p0), .clr(clr), .en(en), .cnt(c0));
  dcpwm_load load_one_inst (.clk(clk), .pin(p1), .clr(clr), .en(en), .cnt(c1));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // bus, measure and compare tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1;
    @(negedge clk);
    wr_s = 0;
    // strobe low across one edge so back-to-back calls never reassign it
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_s = 1;
    @(negedge clk);
    rd_s = 0;
    check({8'h00, rdata}, {8'h00, exp});
    @(negedge clk);
  endtask
  task automatic measure(input logic [15:0] len);
    clr = 1;
    @(negedge clk);
    clr = 0;
    en = 1;
    repeat (len) @(negedge clk);
    en = 0;
  endtask
  task automatic stop_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard: the whole run needs about 12k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    rd(8'ha1, 8'h00);
    rd(8'ha2, 8'h00);
    rd(8'hb2, 8'h00);
    rd(8'hb3, 8'h00);
    wr(8'hb2, 8'h6d);
    rd(8'hb2, 8'h6d);
    // each code with its own prescale; upper duty bits must be dropped
    for (int r = 0; r < 4; r++) begin
      base = (16'h0001 << (r + 5)) - 16'h0001;
      wr(8'hb2, {r[1:0], 4'(r * 5), 2'b11});
      wr(8'ha1, 8'ha3);
      wr(8'ha2, 8'hff);
      n = base * 16'(r * 5 + 1);
      repeat (n) @(negedge clk);
      measure(n);
      check(c0, (16'h00a3 & base) * 16'(r * 5 + 1));
      check(c1, n);
    end
    wr(8'hb2, 8'hfc);
    measure(16'd300);
    check(c0, 16'h0000);
    check(c1, 16'h0000);
    wr(8'hb2, 8'h01);
    wr(8'ha1, 8'h1f);
    repeat (4) @(negedge clk);
    check({15'h0000, p0}, 16'h0001);
    wr(8'ha1, 8'h00);
    repeat (2) @(negedge clk);
    check({15'h0000, p0}, 16'h0000);
    // duty raised mid-window: high count must lie between old and new duty
    wr(8'ha1, 8'h0a);
    repeat (40) @(negedge clk);
    fork
      measure(16'h001f);
      begin
        repeat (10) @(negedge clk);
        wr(8'ha1, 8'h14);
      end
    join
    check({15'h0000, c0 >= 16'h000a && c0 <= 16'h0014}, 16'h0001);
    // clock enable low: output frozen and writes ignored
    n = {15'h0000, p0};
    ce = 0;
    wr(8'ha1, 8'h1f);
    check({15'h0000, p0}, n);
    ce = 1;
    rd(8'ha1, 8'h14);
    stop_test();
  end
endmodule
